// >>> common/serial_interrupt_pin_host_defines.svh
// Timing counts and field constants for the serial interrupt host controller
// Notes on behaviour
// - Host stretches start low to four-eight clocks.
// - Continuous mode: only host starts cycles.
// - Mode changes only during stop, by width.
// - Stop low two clocks quiet, three continuous.
// - Next start two clocks after stop rise.
// - Only host stops, after all data frames.
// - Drive and sample on rising clock edge.
// - Reset tri-states line; starts in Continuous mode.
// - Host runs first cycle after reset.
// - Host should idle continuous before reconfiguration.
`ifndef SERIAL_INTERRUPT_PIN_HOST_DEFINES_SVH
`define SERIAL_INTERRUPT_PIN_HOST_DEFINES_SVH

`define SERIAL_INTERRUPT_PIN_FRAMES_DEF   17
`define SERIAL_INTERRUPT_PIN_IDX_W        6
`define SERIAL_INTERRUPT_PIN_CNT_W        4
`define SERIAL_INTERRUPT_PIN_START_MIN    4'h4
`define SERIAL_INTERRUPT_PIN_START_MAX    4'h8
`define SERIAL_INTERRUPT_PIN_STOP_QUIET   4'h2
`define SERIAL_INTERRUPT_PIN_STOP_CONT    4'h3
`define SERIAL_INTERRUPT_PIN_SYNC_STAGES  2
`define SERIAL_INTERRUPT_PIN_LEVELS_RST   1'b1

`endif

// >>> common/serial_interrupt_pin_host_pkg.sv
// Types shared by the serial interrupt host controller
package serial_interrupt_pin_host_pkg;

  // Host sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START_LOW,
    ST_START_HIGH,
    ST_DATA,
    ST_STOP_LOW,
    ST_STOP_HIGH,
    ST_STOP_GAP
  } host_state_t;

  // Phase inside one data frame
  typedef enum logic [1:0] {
    PH_TURN,
    PH_SAMPLE,
    PH_RECOVER
  } frame_phase_t;

endpackage

// >>> common/serial_interrupt_pin_host_if.sv
// Sample strobe bundle between the host sequencer and the frame decoder
`timescale 1ns/1ps
`default_nettype none
`include "serial_interrupt_pin_host_defines.svh"
interface serial_interrupt_pin_host_if;
  logic                     sampleStb;
  logic [`SERIAL_INTERRUPT_PIN_IDX_W-1:0]   frameIdx;
  logic                     cycleEnd;
  logic                     lineSync;

  modport ctrl (output sampleStb, output frameIdx, output cycleEnd, output lineSync);
  modport dec  (input sampleStb, input frameIdx, input cycleEnd, input lineSync);
endinterface // serial_interrupt_pin_host_if
`default_nettype wire

// >>> logic/serial_interrupt_pin_pin_sync.sv
// Two-flop synchroniser for the shared serial interrupt line
`timescale 1ns/1ps
`default_nettype none
module serial_interrupt_pin_pin_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  output logic      pinSync
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;

  sync_state_t r;
  sync_state_t n;

  // Second stage alone reads the first
  always_comb begin
    n    = r;
    n.s1 = pinIn;
    n.s2 = r.s1;
  end

  // Line idles high through its pull-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{s1: 1'b1, s2: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign pinSync = r.s2;
endmodule // serial_interrupt_pin_pin_sync
`default_nettype wire

// >>> logic/serial_interrupt_pin_frame_decoder.sv
// Collects sampled data-frame levels, aligned to the synchroniser delay
`timescale 1ns/1ps
`default_nettype none
`include "serial_interrupt_pin_host_defines.svh"
module serial_interrupt_pin_frame_decoder
  import serial_interrupt_pin_host_pkg::*;
#(
  parameter int NUM_FRAMES = `SERIAL_INTERRUPT_PIN_FRAMES_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  serial_interrupt_pin_host_if.dec                   bus,
  output logic [NUM_FRAMES-1:0]      frameLevel,
  output logic                       levelsValid
);
  typedef struct packed {
    logic [`SERIAL_INTERRUPT_PIN_SYNC_STAGES-1:0]                   stbPipe;
    logic [`SERIAL_INTERRUPT_PIN_SYNC_STAGES-1:0][`SERIAL_INTERRUPT_PIN_IDX_W-1:0]  idxPipe;
    logic [`SERIAL_INTERRUPT_PIN_SYNC_STAGES-1:0]                   endPipe;
    logic [NUM_FRAMES-1:0]                          shadow;
    logic [NUM_FRAMES-1:0]                          levels;
    logic                                           valid;
  } dec_state_t;

  dec_state_t r;
  dec_state_t n;

  // Delay the strobe by the synchroniser depth so the line value lines up
  always_comb begin
    n         = r;
    n.stbPipe = {r.stbPipe[`SERIAL_INTERRUPT_PIN_SYNC_STAGES-2:0], bus.sampleStb};
    n.idxPipe = {r.idxPipe[`SERIAL_INTERRUPT_PIN_SYNC_STAGES-2:0], bus.frameIdx};
    n.endPipe = {r.endPipe[`SERIAL_INTERRUPT_PIN_SYNC_STAGES-2:0], bus.cycleEnd};
    n.valid   = 1'b0;
    for (int i = 0; i < NUM_FRAMES; i++) begin
      if (r.stbPipe[`SERIAL_INTERRUPT_PIN_SYNC_STAGES-1] && r.idxPipe[`SERIAL_INTERRUPT_PIN_SYNC_STAGES-1] == `SERIAL_INTERRUPT_PIN_IDX_W'(i)) begin
        n.shadow[i] = bus.lineSync;
      end
    end
    // Publish the whole cycle at once; bit k is frame k+1
    if (r.endPipe[`SERIAL_INTERRUPT_PIN_SYNC_STAGES-1]) begin
      n.levels = r.shadow;
      n.valid  = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{stbPipe: '0, idxPipe: '0, endPipe: '0,
             shadow: {NUM_FRAMES{`SERIAL_INTERRUPT_PIN_LEVELS_RST}}, levels: {NUM_FRAMES{`SERIAL_INTERRUPT_PIN_LEVELS_RST}}, valid: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign frameLevel  = r.levels;
  assign levelsValid = r.valid;
endmodule // serial_interrupt_pin_frame_decoder
`default_nettype wire

// >>> logic/serial_interrupt_pin_host_ctrl.sv
// Host end of the serialized interrupt line: start, data and stop frames
`timescale 1ns/1ps
`default_nettype none
`include "serial_interrupt_pin_host_defines.svh"
module serial_interrupt_pin_host_ctrl
  import serial_interrupt_pin_host_pkg::*;
#(
  parameter int NUM_FRAMES = `SERIAL_INTERRUPT_PIN_FRAMES_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  serialInterruptPinIn,
  output logic                       serialInterruptPinOut,
  output logic                       serialInterruptPinOe,
  input  wire logic [3:0]            startWidth,
  input  wire logic                  quietReq,
  input  wire logic                  contRun,
  input  wire logic                  hostStartReq,
  output logic [NUM_FRAMES-1:0]      frameLevel,
  output logic                       levelsValid,
  output logic                       firstCycleDone,
  output logic                       modeQuiet,
  output logic                       busy
);
  typedef struct packed {
    host_state_t            st;
    logic [`SERIAL_INTERRUPT_PIN_CNT_W-1:0] cnt;
    frame_phase_t           ph;
    logic [`SERIAL_INTERRUPT_PIN_IDX_W-1:0] frame;
    logic                   modeQuiet;
    logic                   stopQuiet;
    logic                   firstPending;
    logic                   pinOut;
    logic                   pinOe;
    logic [`SERIAL_INTERRUPT_PIN_CNT_W-1:0] lowRun;
  } ctrl_state_t;

  ctrl_state_t r;
  ctrl_state_t n;
  logic        lineSync;
  logic        startWant;

  serial_interrupt_pin_host_if link ();

  // Clamp the programmed start width to the legal range
  function automatic logic [`SERIAL_INTERRUPT_PIN_CNT_W-1:0] clampWidth(input logic [3:0] w);
    if (w < `SERIAL_INTERRUPT_PIN_START_MIN) begin
      return `SERIAL_INTERRUPT_PIN_START_MIN;
    end else if (w > `SERIAL_INTERRUPT_PIN_START_MAX) begin
      return `SERIAL_INTERRUPT_PIN_START_MAX;
    end else begin
      return w;
    end
  endfunction

  // Stop pulse width for the requested next mode
  function automatic logic [`SERIAL_INTERRUPT_PIN_CNT_W-1:0] stopWidth(input logic quiet);
    return quiet ? `SERIAL_INTERRUPT_PIN_STOP_QUIET : `SERIAL_INTERRUPT_PIN_STOP_CONT;
  endfunction

  // Line level seen two clocks late
  serial_interrupt_pin_pin_sync u_sync (
    .clk     (clk),
    .arst_n  (arst_n),
    .pinIn   (serialInterruptPinIn),
    .pinSync (lineSync)
  );

  // Reasons to open a cycle from idle
  always_comb begin
    startWant = r.firstPending
              || (!r.modeQuiet && contRun)
              || (r.modeQuiet && (hostStartReq || !lineSync));
  end

  // Sequencer next state
  always_comb begin
    n = r;
    case (r.st)
      ST_IDLE: begin
        if (startWant) begin
          n.st  = ST_START_LOW;
          n.cnt = '0;
        end
      end
      ST_START_LOW: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt >= clampWidth(startWidth) - 1'b1) begin
          n.st = ST_START_HIGH;
        end
      end
      ST_START_HIGH: begin
        n.st    = ST_DATA;
        n.ph    = PH_TURN;
        n.frame = '0;
      end
      ST_DATA: begin
        case (r.ph)
          PH_TURN: begin
            if (r.frame == `SERIAL_INTERRUPT_PIN_IDX_W'(NUM_FRAMES)) begin
              n.st        = ST_STOP_LOW;
              n.cnt       = '0;
              n.stopQuiet = quietReq;
            end else begin
              n.ph = PH_SAMPLE;
            end
          end
          PH_SAMPLE: begin
            n.ph    = PH_RECOVER;
            n.frame = r.frame + 1'b1;
          end
          default: begin
            n.ph = PH_TURN;
          end
        endcase
      end
      ST_STOP_LOW: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == stopWidth(r.stopQuiet) - 1'b1) begin
          n.st           = ST_STOP_HIGH;
          n.modeQuiet    = r.stopQuiet;
          n.firstPending = 1'b0;
        end
      end
      ST_STOP_HIGH: begin
        n.st = ST_STOP_GAP;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // Pin drive follows the state; every drive is registered on the clock
    n.pinOe  = n.st inside {ST_START_LOW, ST_START_HIGH, ST_STOP_LOW, ST_STOP_HIGH};
    n.pinOut = n.st inside {ST_START_HIGH, ST_STOP_HIGH};
    // Length of the present low drive, for checking only
    if (r.pinOe && !r.pinOut) begin
      n.lowRun = (r.lowRun == '1) ? r.lowRun : r.lowRun + 1'b1;
    end else begin
      n.lowRun = '0;
    end
  end

  // Reset releases the line and selects Continuous mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: ST_IDLE, cnt: '0, ph: PH_TURN, frame: '0, modeQuiet: 1'b0, stopQuiet: 1'b0,
             firstPending: 1'b1, pinOut: 1'b1, pinOe: 1'b0, lowRun: '0};
    end else begin
      r <= n;
    end
  end

  // Strobes toward the decoder
  assign link.sampleStb = (r.st == ST_DATA) && (r.ph == PH_SAMPLE);
  assign link.frameIdx  = r.frame;
  assign link.cycleEnd  = (r.st == ST_DATA) && (r.ph == PH_TURN) && (r.frame == `SERIAL_INTERRUPT_PIN_IDX_W'(NUM_FRAMES));
  assign link.lineSync  = lineSync;

  serial_interrupt_pin_frame_decoder #(
    .NUM_FRAMES (NUM_FRAMES)
  ) u_dec (
    .clk         (clk),
    .arst_n      (arst_n),
    .bus         (link.dec),
    .frameLevel  (frameLevel),
    .levelsValid (levelsValid)
  );

  // Outputs
  assign serialInterruptPinOut = r.pinOut;
  assign serialInterruptPinOe  = r.pinOe;
  assign firstCycleDone        = !r.firstPending;
  assign modeQuiet             = r.modeQuiet;
  assign busy                  = (r.st != ST_IDLE);

  // Start pulse is four to eight low clocks, then one high clock
  property p_start_width;
    @(posedge clk) disable iff (!arst_n)
      (r.st == ST_START_HIGH) |-> (r.lowRun >= `SERIAL_INTERRUPT_PIN_START_MIN) && (r.lowRun <= `SERIAL_INTERRUPT_PIN_START_MAX)
                                  && r.pinOe && r.pinOut;
  endproperty
  a_start_width: assert property (p_start_width) else $error("start pulse width out of range");

  // Line released right after the high clock of start
  property p_start_release;
    @(posedge clk) disable iff (!arst_n)
      (r.st == ST_START_HIGH) |=> !r.pinOe [*3];
  endproperty
  a_start_release: assert property (p_start_release) else $error("line not released after start");

  // Stop low width tracks the mode it selects
  property p_stop_width;
    @(posedge clk) disable iff (!arst_n)
      (r.st == ST_STOP_HIGH) |-> (r.lowRun == stopWidth(r.modeQuiet)) && r.pinOut;
  endproperty
  a_stop_width: assert property (p_stop_width) else $error("stop width does not match mode");

  // Mode changes only at the end of a stop pulse
  property p_mode_in_stop;
    @(posedge clk) disable iff (!arst_n)
      $changed(r.modeQuiet) |-> (r.st == ST_STOP_HIGH) && ($past(r.st) == ST_STOP_LOW);
  endproperty
  a_mode_in_stop: assert property (p_mode_in_stop) else $error("mode changed outside stop");

  // Stop begins only once every data frame has passed
  property p_stop_after_frames;
    @(posedge clk) disable iff (!arst_n)
      (r.st == ST_STOP_LOW) && ($past(r.st) == ST_DATA) |-> ($past(r.frame) == `SERIAL_INTERRUPT_PIN_IDX_W'(NUM_FRAMES));
  endproperty
  a_stop_after_frames: assert property (p_stop_after_frames) else $error("stop before last frame");

  // No drive for two clocks after the stop rising edge
  property p_stop_gap;
    @(posedge clk) disable iff (!arst_n)
      (r.st == ST_STOP_HIGH) |=> !r.pinOe ##1 !r.pinOe;
  endproperty
  a_stop_gap: assert property (p_stop_gap) else $error("start too soon after stop");

  // Host never drives during data frames
  property p_data_passive;
    @(posedge clk) disable iff (!arst_n)
      (r.st == ST_DATA) |-> !r.pinOe;
  endproperty
  a_data_passive: assert property (p_data_passive) else $error("host drove a data frame");

  // First cycle after reset opens at once
  property p_first_cycle;
    @(posedge clk) disable iff (!arst_n)
      (r.st == ST_IDLE) && r.firstPending |=> (r.st == ST_START_LOW) && r.pinOe && !r.pinOut;
  endproperty
  a_first_cycle: assert property (p_first_cycle) else $error("first cycle not started");

  // Continuous running restarts right after the stop gap
  property p_cont_restart;
    @(posedge clk) disable iff (!arst_n)
      (r.st == ST_IDLE) && !r.modeQuiet && contRun |=> (r.st == ST_START_LOW);
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("continuous restart missed");

  // Data frames last exactly three clocks each; the last turn-around ends the cycle
  property p_frame_len;
    @(posedge clk) disable iff (!arst_n)
      link.sampleStb |=> !link.sampleStb ##1 !link.sampleStb ##1 (link.sampleStb || $past(link.cycleEnd));
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length not three clocks");
endmodule // serial_interrupt_pin_host_ctrl
`default_nettype wire

// >>> bench/serial_interrupt_pin_device_model.sv
// Device-side serial interrupt agent that answers the host controller
`timescale 1ns/1ps
`default_nettype none
module serial_interrupt_pin_device_model #(
  parameter int NF = 17
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          lineIn,
  input  wire logic [NF-1:0] irqN,
  input  wire logic          smiN,
  input  wire logic [7:0]    mgmtEn,
  input  wire logic          wantStart,
  output logic               devOe,
  output logic               devOut,
  output logic               mgmtIntN
);
  logic [NF-1:0] lastLv;
  logic [7:0]    k;
  logic [3:0]    runL;
  logic [2:0]    gap;
  logic          act, quiet, prevW, drove, sent;
  int            nk;

  // Dedicated management pin follows its own enable bit
  assign mgmtIntN = mgmtEn[7] ? smiN : 1'b1;

  // Line is sampled and driven on the rising edge only
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      devOe <= 1'b0;
      devOut <= 1'b1;
      quiet <= 1'b0;
      act <= 1'b0;
      k <= 8'h00;
      runL <= 4'h0;
      gap <= 3'h0;
      prevW <= 1'b1;
      drove <= 1'b0;
      sent <= 1'b0;
      lastLv <= {NF{1'b1}};
    end else begin
      // Frame one unused, frame three shared by management and IRQ2
      lastLv <= (irqN | NF'(1)) & ~(NF'(!smiN && mgmtEn[6]) << 2);
      prevW <= lineIn;
      runL <= lineIn ? 4'h0 : runL + 4'h1;
      gap <= (gap == 3'h7) ? gap : gap + 3'h1;
      nk = k + 1;
      devOe <= 1'b0;
      devOut <= 1'b1;
      drove <= 1'b0;
      if (lineIn && !prevW && runL >= 4'h4 && !act) begin
        act <= 1'b1;
        k <= 8'h01;
        sent <= 1'b0;
      end else if (act) begin
        k <= nk[7:0];
        act <= (nk < 3 * NF + 1);
        if (nk % 3 == 2 && !lastLv[nk / 3]) begin
          devOe <= 1'b1;
          devOut <= 1'b0;
          drove <= 1'b1;
        end else if (nk % 3 == 0 && drove) begin
          devOe <= 1'b1;
        end
      end else if (quiet && wantStart && !sent && gap >= 3'h2 && lineIn) begin
        devOe <= 1'b1;
        devOut <= 1'b0;
        sent <= 1'b1;
      end
      // Stop width picks the mode of the next cycle
      if (lineIn && !prevW && (runL == 4'h2 || runL == 4'h3)) begin
        quiet <= (runL == 4'h2);
        gap <= 3'h0;
      end
    end
  end
endmodule // serial_interrupt_pin_device_model
`default_nettype wire

// >>> bench/serial_interrupt_pin_host_ctrl_bench.sv
// Self-checking bench for the serial interrupt host controller
`timescale 1ns/1ps
`default_nettype none
module serial_interrupt_pin_host_ctrl_bench;
  localparam int NF = 17;
  logic          clk;
  logic          arst_n       = 1'b0;
  logic [3:0]    startWidth   = 4'h6;
  logic          quietReq     = 1'b0;
  logic          contRun      = 1'b0;
  logic          hostStartReq = 1'b0;
  logic [NF-1:0] irqN         = 17'h15A5B;
  logic          smiN         = 1'b1;
  logic [7:0]    mgmtEn       = 8'h00;
  logic          wantStart    = 1'b0;
  logic [NF-1:0] frameLevel;
  logic          hostOut, hostOe, devOe, devOut, levelsValid, firstCycleDone, modeQuiet, busy;
  logic          prevW        = 1'b1;
  logic          inCyc        = 1'b0;
  logic          expQ         = 1'b0;
  int            error_cnt    = 0;
  int            comparisons  = 0;
  int            runL         = 0;
  int            sinceSt      = 99;
  int            expW         = 4;
  wire           lineW        = hostOe ? hostOut : (devOe ? devOut : 1'b1);

  serial_interrupt_pin_host_ctrl #(.NUM_FRAMES(NF)) u_dut (
    .clk(clk), .arst_n(arst_n), .serialInterruptPinIn(lineW), .serialInterruptPinOut(hostOut),
    .serialInterruptPinOe(hostOe), .startWidth(startWidth), .quietReq(quietReq), .contRun(contRun),
    .hostStartReq(hostStartReq), .frameLevel(frameLevel), .levelsValid(levelsValid),
    .firstCycleDone(firstCycleDone), .modeQuiet(modeQuiet), .busy(busy));

  serial_interrupt_pin_device_model #(.NF(NF)) u_dev (
    .clk(clk), .arst_n(arst_n), .lineIn(lineW), .irqN(irqN), .smiN(smiN), .mgmtEn(mgmtEn),
    .wantStart(wantStart), .devOe(devOe), .devOut(devOut), .mgmtIntN());

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Wait for busy low (idle=1) or a levels pulse (idle=0), bounded
  task automatic wait_on(input bit idle);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400) begin
        chk(32'(0), 32'(1), "wait ran out");
        report_and_stop;
      end
    end while (idle ? busy !== 1'b0 : levelsValid !== 1'b1);
  endtask

  function automatic logic [NF-1:0] expv();
    logic [NF-1:0] e;
    e = irqN;
    e[0] = 1'b1;
    e[2] = irqN[2] & (smiN | !mgmtEn[6]);
    return e;
  endfunction

  // Line watcher: start width, spacing, stop position and width
  always @(posedge clk) begin
    sinceSt++;
    if (!lineW) runL++;
    if (arst_n && !lineW && prevW) begin
      if (inCyc && sinceSt > 3 * NF) begin
        chk(32'(sinceSt), 32'(3 * NF + 2), "stop position");
        expQ = quietReq;
        inCyc = 1'b0;
      end else if (!inCyc) begin
        chk(32'(sinceSt >= 2), 32'(1), "start spacing");
        expW = startWidth < 4 ? 4 : (startWidth > 8 ? 8 : int'(startWidth));
      end
    end
    if (arst_n && lineW && !prevW && runL >= 4) begin
      chk(32'(runL), 32'(expW), "start width");
      inCyc = 1'b1;
      sinceSt = 0;
    end else if (arst_n && lineW && !prevW && runL >= 2) begin
      chk(32'(runL), expQ ? 32'(2) : 32'(3), "stop width");
      sinceSt = 0;
    end
    if (lineW) runL = 0;
    prevW = lineW;
  end

  task automatic t_reset;
    repeat (12) @(posedge clk);
    #1;
    chk(32'({hostOe, hostOut, busy, modeQuiet, firstCycleDone, levelsValid}), 32'h10, "reset state");
    chk(32'(frameLevel), 32'(17'h1FFFF), "reset levels");
    arst_n = 1'b1;
    $display("test reset done");
  endtask

  task automatic t_first;
    wait_on(0);
    chk(32'(frameLevel), 32'(expv()), "first levels");
    wait_on(1);
    chk(32'({firstCycleDone, modeQuiet}), 32'h2, "first cycle");
    $display("test first cycle done");
  endtask

  task automatic t_cont;
    contRun = 1'b1;
    startWidth = 4'hF;
    for (int i = 0; i < 3; i++) begin
      wait_on(0);
      chk(32'(frameLevel), 32'(expv()), "continuous levels");
      irqN = irqN ^ 17'h0A5C6;
      smiN = i[0];
      mgmtEn = 8'hC0;
      startWidth = (i == 0) ? 4'h1 : 4'h8;
    end
    $display("test continuous done");
  endtask

  task automatic t_quiet;
    quietReq = 1'b1;
    wait_on(0);
    contRun = 1'b0;
    wait_on(1);
    chk(32'(modeQuiet), 32'(1), "quiet mode");
    repeat (20) @(posedge clk);
    #1;
    chk(32'(busy), 32'(0), "quiet idle");
    irqN = 17'h0F0F3;
    wantStart = 1'b1;
    wait_on(0);
    chk(32'(frameLevel), 32'(expv()), "device start levels");
    wantStart = 1'b0;
    quietReq = 1'b0;
    hostStartReq = 1'b1;
    irqN = 17'h1E1EE;
    wait_on(0);
    chk(32'(frameLevel), 32'(expv()), "host quiet levels");
    hostStartReq = 1'b0;
    wait_on(1);
    chk(32'(modeQuiet), 32'(0), "back to continuous");
    wantStart = 1'b1;
    repeat (30) @(posedge clk);
    #1;
    chk(32'(busy), 32'(0), "device passive");
    wantStart = 1'b0;
    $display("test quiet done");
  endtask

  // Main sequence
  initial begin
    t_reset;
    t_first;
    t_cont;
    t_quiet;
    report_and_stop;
  end
endmodule // serial_interrupt_pin_host_ctrl_bench
`default_nettype wire
